// File: logic/wos_consts.vh
// constants for the waveform output steering block
// Operation
// - steering enabled: output carries shaped waveform, polarity applied.
// - steering disabled: output carries its override level.
// - steering and override bits act only in modes 000 and 001.
// - in mode 001 steering enables take effect only at the buffered update point.
// - clock select 1 picks fast internal oscillator, 0 picks system clock.
// - input selector codes route pin, comparators, capture units, logic cells, pulse gens.
// - reserved selector codes connect no source to the generator input.
// - unused upper bits of input and clock select registers ignore writes, read zero.
// - polarity bit 1 inverts the steered waveform, 0 leaves it normal.
`ifndef WOS_CONSTS_VH
`define WOS_CONSTS_VH
`define WOS_ADDR_W        4
`define WOS_ADDR_STEER    4'h0
`define WOS_ADDR_CLKSEL   4'h1
`define WOS_ADDR_INSEL    4'h2
`define WOS_ADDR_CTRL0    4'h3
`define WOS_ADDR_CTRL1    4'h4
`define WOS_ADDR_STATUS   4'h5
`define WOS_RST_STEER     8'h00
`define WOS_RST_OVR       4'h0
`define WOS_RST_ENA       4'h0
`define WOS_RST_CLKSEL    1'b0
`define WOS_RST_INSEL     4'h0
`define WOS_RST_MODE      3'h0
`define WOS_RST_POL       4'h0
`define WOS_MODE_STEER_A  3'h0
`define WOS_MODE_STEER_S  3'h1
`define WOS_IS_PIN        4'h0
`define WOS_IS_CMP1       4'h1
`define WOS_IS_CMP2       4'h2
`define WOS_IS_CCP1       4'h3
`define WOS_IS_CCP2       4'h4
`define WOS_IS_LC1        4'h5
`define WOS_IS_LC2        4'h6
`define WOS_IS_PG3        4'h9
`define WOS_IS_PG4        4'hA
`endif

// File: logic/wos_sync3.v
// three-flop input synchroniser with agreement filter
`default_nettype none
module wos_sync3 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         arst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] s1;
  reg [W-1:0] s2;
  reg [W-1:0] s3;
  integer i;
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1 <= {W{1'b0}};
      s2 <= {W{1'b0}};
      s3 <= {W{1'b0}};
      q  <= {W{1'b0}};
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      // only stages two and three vote
      for (i = 0; i < W; i = i + 1) begin
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end
endmodule // wos_sync3
`default_nettype wire

// File: logic/wos_top.v
// output steering, clock and input selection of the waveform generator
`default_nettype none
`include "wos_consts.vh"
module wos_top (
  input  wire                   CLOCK,
  input  wire                   ARST_N,
  input  wire [`WOS_ADDR_W-1:0] ADDR,
  input  wire [7:0]             WDATA,
  input  wire                   WR,
  input  wire                   RD,
  output reg  [7:0]             RDATA,
  input  wire                   FAST_INTERNAL_OSC,
  input  wire                   WAVEFORM_INPUT_PIN,
  input  wire                   COMPARATOR1_SYNCED,
  input  wire                   COMPARATOR2_SYNCED,
  input  wire                   CAPTURE_UNIT1_OUT,
  input  wire                   CAPTURE_UNIT2_OUT,
  input  wire                   LOGIC_CELL1_OUT,
  input  wire                   LOGIC_CELL2_OUT,
  input  wire                   PULSE_GEN3_OUT,
  input  wire                   PULSE_GEN4_OUT,
  input  wire                   SHAPED_WAVEFORM,
  input  wire                   UPDATE_POINT,
  output reg                    SELECTED_INPUT,
  output reg                    GEN_CLOCK_ENABLE,
  output reg                    OUTPUT_A,
  output reg                    OUTPUT_B,
  output reg                    OUTPUT_C,
  output reg                    OUTPUT_D
);
  // register file
  reg [3:0] override_level;
  reg [3:0] steer_enable;
  reg [3:0] steer_live;
  reg       clock_sel;
  reg [3:0] input_source_sel;
  reg [2:0] mode;
  reg [3:0] invert_output;

  // external inputs pass the three-flop filter
  wire [9:0] ext_raw;
  wire [9:0] ext;
  assign ext_raw = {FAST_INTERNAL_OSC, WAVEFORM_INPUT_PIN, COMPARATOR1_SYNCED,
                    COMPARATOR2_SYNCED, CAPTURE_UNIT1_OUT, CAPTURE_UNIT2_OUT,
                    LOGIC_CELL1_OUT, LOGIC_CELL2_OUT, PULSE_GEN3_OUT, PULSE_GEN4_OUT};

  wos_sync3 #(.W(10)) u_sync (
    .clk    (CLOCK),
    .arst_n (ARST_N),
    .d      (ext_raw),
    .q      (ext)
  );

  wire fosc_in = ext[9];

  function source_pick;
    input [3:0] sel;
    input [8:0] src;
    begin
      case (sel)
        `WOS_IS_PIN:  source_pick = src[8];
        `WOS_IS_CMP1: source_pick = src[7];
        `WOS_IS_CMP2: source_pick = src[6];
        `WOS_IS_CCP1: source_pick = src[5];
        `WOS_IS_CCP2: source_pick = src[4];
        `WOS_IS_LC1:  source_pick = src[3];
        `WOS_IS_LC2:  source_pick = src[2];
        `WOS_IS_PG3:  source_pick = src[1];
        `WOS_IS_PG4:  source_pick = src[0];
        default:      source_pick = 1'b0;
      endcase
    end
  endfunction

  // rising edge of the filtered fast oscillator is the generator tick
  reg  fosc_prev;
  wire fast_tick = fosc_in & ~fosc_prev;
  wire gen_tick  = clock_sel ? fast_tick : 1'b1;

  // register writes
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      override_level   <= `WOS_RST_OVR;
      steer_enable     <= `WOS_RST_ENA;
      clock_sel        <= `WOS_RST_CLKSEL;
      input_source_sel <= `WOS_RST_INSEL;
      mode             <= `WOS_RST_MODE;
      invert_output    <= `WOS_RST_POL;
    end else if (WR) begin
      case (ADDR)
        `WOS_ADDR_STEER: begin
          override_level <= WDATA[7:4];
          steer_enable   <= WDATA[3:0];
        end
        `WOS_ADDR_CLKSEL: clock_sel        <= WDATA[0];
        `WOS_ADDR_INSEL:  input_source_sel <= WDATA[3:0];
        `WOS_ADDR_CTRL0:  mode             <= WDATA[2:0];
        `WOS_ADDR_CTRL1:  invert_output    <= WDATA[3:0];
        default: ;
      endcase
    end
  end

  // register reads, one cycle later
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `WOS_ADDR_STEER:  RDATA <= {override_level, steer_enable};
        `WOS_ADDR_CLKSEL: RDATA <= {7'h00, clock_sel};
        `WOS_ADDR_INSEL:  RDATA <= {4'h0, input_source_sel};
        `WOS_ADDR_CTRL0:  RDATA <= {5'h00, mode};
        `WOS_ADDR_CTRL1:  RDATA <= {2'h0, SELECTED_INPUT, 1'b0, invert_output};
        `WOS_ADDR_STATUS: RDATA <= {OUTPUT_D, OUTPUT_C, OUTPUT_B, OUTPUT_A, steer_live};
        default:          RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  wire steer_mode = (mode == `WOS_MODE_STEER_A) || (mode == `WOS_MODE_STEER_S);

  // steering enables in effect; buffered in synchronous mode
  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      steer_live <= `WOS_RST_ENA;
    end else if (mode == `WOS_MODE_STEER_S) begin
      if (UPDATE_POINT) begin
        steer_live <= steer_enable;
      end
    end else begin
      steer_live <= steer_enable;
    end
  end

  // outputs refresh only on the generator tick, so a steering change lands on it
  reg [3:0] next_out;
  integer k;
  always @* begin
    for (k = 0; k < 4; k = k + 1) begin
      if (!steer_mode) begin
        next_out[k] = SHAPED_WAVEFORM ^ invert_output[k];
      end else if (steer_live[k]) begin
        next_out[k] = SHAPED_WAVEFORM ^ invert_output[k];
      end else begin
        next_out[k] = override_level[k];
      end
    end
  end

  always @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      fosc_prev        <= 1'b0;
      GEN_CLOCK_ENABLE <= 1'b0;
      SELECTED_INPUT   <= 1'b0;
      OUTPUT_A         <= 1'b0;
      OUTPUT_B         <= 1'b0;
      OUTPUT_C         <= 1'b0;
      OUTPUT_D         <= 1'b0;
    end else begin
      fosc_prev        <= fosc_in;
      GEN_CLOCK_ENABLE <= gen_tick;
      SELECTED_INPUT   <= source_pick(input_source_sel, ext[8:0]);
      if (gen_tick) begin
        OUTPUT_A <= next_out[0];
        OUTPUT_B <= next_out[1];
        OUTPUT_C <= next_out[2];
        OUTPUT_D <= next_out[3];
      end
    end
  end
endmodule // wos_top
`default_nettype wire

// File: dv/wos_props.sv
// assertion checker for the waveform output steering block
`default_nettype none
module wos_props (
  input wire logic       CLOCK,
  input wire logic       ARST_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       WAVEFORM_INPUT_PIN,
  input wire logic       SHAPED_WAVEFORM,
  input wire logic       SELECTED_INPUT,
  input wire logic       GEN_CLOCK_ENABLE,
  input wire logic       OUTPUT_A,
  input wire logic       OUTPUT_B,
  input wire logic       OUTPUT_C,
  input wire logic       OUTPUT_D
);
  logic [7:0] r [0:4];
  wire  [3:0] o = {OUTPUT_D, OUTPUT_C, OUTPUT_B, OUTPUT_A};
  wire  [3:0] w = {4{SHAPED_WAVEFORM}} ^ r[4][3:0];
  wire  [3:0] e = r[0][3:0];
  // shadow kept from the write strobe alone, never from read data
  always_ff @(posedge CLOCK or negedge ARST_N)
    if (!ARST_N) r <= '{default: 8'h00};
    else if (WR && ADDR < 4'h5) r[ADDR] <= WDATA;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);
  chk_steer_out: assert property (
    (!WR && !r[1][0] && r[3][2:0] == 3'h0 && $stable(SHAPED_WAVEFORM))[*5]
    |-> o == ((e & w) | (~e & r[0][7:4]))) else $error("bad steer");
  chk_mode_other: assert property (
    (!WR && !r[1][0] && r[3][2:1] != 2'h0 && $stable(SHAPED_WAVEFORM))[*5]
    |-> o == w) else $error("bad mode");
  chk_sys_tick: assert property ((!r[1][0])[*3] |-> GEN_CLOCK_ENABLE) else $error("no tick");
  chk_fast_pulse: assert property (
    (r[1][0])[*3] ##0 GEN_CLOCK_ENABLE |=> !GEN_CLOCK_ENABLE) else $error("long tick");
  chk_pin_route: assert property (
    (r[2][3:0] == 4'h0 && $stable(WAVEFORM_INPUT_PIN))[*8]
    |-> SELECTED_INPUT == WAVEFORM_INPUT_PIN) else $error("bad route");
  chk_reserved_none: assert property (
    (r[2][3:0] inside {4'h7, 4'h8, [4'hB:4'hF]})[*8] |-> !SELECTED_INPUT) else $error("bad code");
  chk_clk_upper: assert property (
    $past(RD) && $past(ADDR) == 4'h1 |-> RDATA[7:1] == 7'h00) else $error("clk bits");
  chk_isel_upper: assert property (
    $past(RD) && $past(ADDR) == 4'h2 |-> RDATA[7:4] == 4'h0) else $error("isel bits");
  cover property (r[1][0] && GEN_CLOCK_ENABLE);
  cover property (r[3][2:0] == 3'h1 && o == 4'h3);
  cover property (SELECTED_INPUT);
endmodule // wos_props
bind wos_top wos_props u_wos_props (.CLOCK, .ARST_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
  .WAVEFORM_INPUT_PIN, .SHAPED_WAVEFORM, .SELECTED_INPUT, .GEN_CLOCK_ENABLE,
  .OUTPUT_A, .OUTPUT_B, .OUTPUT_C, .OUTPUT_D);
`default_nettype wire

// File: dv/wos_stage_model.sv
// power stage load seen by the four steered outputs
`default_nettype none
module wos_stage_model (
  input  wire logic [3:0] drive,
  output logic      [3:0] level
);
  timeunit 1ns;
  timeprecision 1ps;
  // pure gate load: no latency, so what it sees is the pin level itself
  assign level = drive;
endmodule // wos_stage_model
`default_nettype wire

// File: dv/test_wos_top.sv
// self-checking bench for the waveform output steering block
`default_nettype none
`include "wos_consts.vh"
module test_wos_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 0, arst_n = 0, wr = 0, rd = 0, fosc = 0, shaped = 0, upd = 0;
  logic       sel, tick;
  logic [3:0] addr = 0, lvl;
  wire  [3:0] outs;
  logic [7:0] wdata = 0, rdata;
  logic [8:0] src = 0;
  byte        m [16] = '{0, 1, 2, 3, 4, 5, 6, 9, 9, 7, 8, 9, 9, 9, 9, 9};
  int         err_total = 0, compares = 0, n;
  always #2 clk = ~clk;
  // free-running, phase unrelated to the system clock
  always #31.25 fosc = ~fosc;
  wos_top u_wos_top (.CLOCK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .FAST_INTERNAL_OSC(fosc), .WAVEFORM_INPUT_PIN(src[0]),
    .COMPARATOR1_SYNCED(src[1]), .COMPARATOR2_SYNCED(src[2]), .CAPTURE_UNIT1_OUT(src[3]),
    .CAPTURE_UNIT2_OUT(src[4]), .LOGIC_CELL1_OUT(src[5]), .LOGIC_CELL2_OUT(src[6]),
    .PULSE_GEN3_OUT(src[7]), .PULSE_GEN4_OUT(src[8]), .SHAPED_WAVEFORM(shaped),
    .UPDATE_POINT(upd), .SELECTED_INPUT(sel), .GEN_CLOCK_ENABLE(tick), .OUTPUT_A(outs[0]),
    .OUTPUT_B(outs[1]), .OUTPUT_C(outs[2]), .OUTPUT_D(outs[3]));
  wos_stage_model u_wos_stage_model (.drive(outs), .level(lvl));
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrt(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // read data lands on the edge just taken, so look mid-cycle
    @(negedge clk);
    chk("rdata", rdata, exp);
  endtask
  task automatic summarize;
    if (err_total == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(20);
    arst_n <= 1'b1;
    for (int a = 0; a < 5; a++) rdc(4'(a), 8'h00);
    wrt(`WOS_ADDR_CLKSEL, 8'hFF);
    rdc(`WOS_ADDR_CLKSEL, 8'h01);
    wrt(`WOS_ADDR_INSEL, 8'hFF);
    rdc(`WOS_ADDR_INSEL, 8'h0F);
    wrt(4'hF, 8'hFF);
    rdc(4'hF, 8'h00);
    n = 0;
    // window edges may clip one oscillator edge either way
    repeat (250) begin
      @(negedge clk);
      n += tick;
    end
    chk("ticks", {7'h00, n inside {[15:17]}}, 8'h01);
    wrt(`WOS_ADDR_CLKSEL, 8'h00);
    wrt(`WOS_ADDR_CTRL1, 8'h03);
    wrt(`WOS_ADDR_STEER, 8'hA5);
    shaped <= 1'b1;
    cyc(8);
    @(negedge clk);
    chk("tick", tick, 8'h01);
    chk("outs", lvl, 8'h0E);
    cyc(1);
    shaped <= 1'b0;
    cyc(8);
    @(negedge clk);
    chk("outs", lvl, 8'h0B);
    wrt(`WOS_ADDR_CTRL0, 8'h02);
    cyc(8);
    @(negedge clk);
    chk("outs", lvl, 8'h03);
    wrt(`WOS_ADDR_CTRL0, 8'h01);
    wrt(`WOS_ADDR_STEER, 8'h0F);
    cyc(8);
    @(negedge clk);
    chk("outs", lvl, 8'h01);
    cyc(1);
    upd <= 1'b1;
    cyc(1);
    upd <= 1'b0;
    cyc(8);
    @(negedge clk);
    chk("outs", lvl, 8'h03);
    rdc(`WOS_ADDR_STATUS, 8'h3F);
    for (int c = 0; c < 16; c++) begin
      wrt(4'h2, 8'(c));
      src <= (m[c] < 9) ? 9'(1 << m[c]) : 9'h1FF;
      cyc(10);
      @(negedge clk);
      chk("source", sel, {7'h00, m[c] < 9});
      cyc(1);
      src <= ~src;
      cyc(10);
      @(negedge clk);
      chk("source", sel, 8'h00);
    end
    summarize();
  end
  initial begin
    cyc(20000);
    err_total++;
    summarize();
  end
endmodule // test_wos_top
`default_nettype wire
